// [sac_adc_model.sv]
// Behavioural converter: timed conversion and serial readout
`default_nettype none
module sac_adc_model
    import sac_pkg::*;
#(
    parameter int CONV_CYC = 150
) (
    // Clock and pins
    input wire logic clock,
    input wire logic convertStrobe,
    input wire logic selectModeInput,
    input wire logic shiftClock,
    output logic serialResultOut,
    // Bench side
    input wire logic [RESULT_BITS-1:0] sampleWord,
    output logic chainSeen,
    output logic busySent
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [RESULT_BITS-1:0] word = '0;
    logic drive = 1'h0;
    logic ready = 1'h0;
    logic junk = 1'h0;
    int cnt = 0;
    int pos = 0;
    wire logic csHigh = convertStrobe & selectModeInput;
    initial chainSeen = 1'h0;
    initial busySent = 1'h0;
    // Released line toggles so a stale bit never reads as valid
    assign serialResultOut = drive ? (pos == 16 ? 1'h0 : word[pos]) : junk;
    always @(posedge clock) junk <= ~junk;
    // A rise during a running conversion is ignored
    always @(posedge convertStrobe) begin
        if (cnt == 0) begin
            if (!selectModeInput) chainSeen = 1'h1;
            word = sampleWord;
            drive = 1'h0;
            ready = 1'h0;
            cnt = CONV_CYC;
        end
    end
    always @(posedge clock) begin
        if (cnt > 0) begin
            cnt = cnt - 1;
            if (cnt == 0) begin
                ready = 1'h1;
                busySent = !csHigh;
                drive = busySent;
                pos = 16;
            end
        end
    end
    always @(negedge csHigh) begin
        if (ready && !busySent && !drive) begin
            drive = 1'h1;
            ready = 1'h0;
            pos = 15;
        end
    end
    always @(posedge csHigh) drive = 1'h0;
    always @(negedge shiftClock) begin
        if (drive && !csHigh) begin
            if (pos == 0) drive = 1'h0;
            else pos = pos - 1;
        end
    end
endmodule
`default_nettype wire

// [sac_host.sv]
// Host controller that starts conversions and reads back results
//
// Functional notes
// RULE1 - Select high before strobe rise picks chip-select mode.
// RULE2 - Select low at strobe rise would pick daisy chain; never done.
// RULE3 - Strobe rise starts conversion; device output floats.
// RULE4 - Conversion runs a fixed time regardless of pins.
// RULE5 - Busy variants send one busy bit before sixteen result bits.
// RULE6 - After conversion the result may be read out.
// RULE7 - 3-wire: select held high; strobe serves as chip select.
// RULE8 - 3-wire no busy: strobe high at conversion end.
// RULE9 - 3-wire no busy: strobe fall gives MSB, shift falls next bits.
// RULE10 - 3-wire no busy: output floats at 16th fall or strobe high.
// RULE11 - 3-wire no busy: host gives at least 15 falls, strobe low.
// RULE12 - 3-wire busy: strobe low before min, held past max time.
// RULE13 - 3-wire busy: low busy bit at end, then MSB per fall.
// RULE14 - 3-wire busy: floats after 17th fall; host gives 16 falls; code gives 17.
// RULE15 - 4-wire: select is chip select; strobe high until read.
// RULE16 - 4-wire no busy: select high at end, lowered after max.
// RULE17 - 4-wire no busy: select fall gives MSB; floats after 16.
// RULE18 - 4-wire busy: select low before min, held past max.
// RULE19 - 4-wire busy: busy bit, then MSB; floats after 17th fall.
// RULE20 - Shared line: next select only after previous floated.
// RULE21 - 4-wire: strobe and select never low together.
// RULE22 - Conversion length is a cycle count; busy from select level.
`default_nettype none
module sac_host
    import sac_pkg::*;
#(
    parameter int NBITS = RESULT_BITS,
    parameter int CONV_CYC = CONV_MAX_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Command side
    input wire logic startReq,
    input wire logic [1:0] modeSel,
    output logic startReady,
    // Result stream
    output logic resValid,
    output logic [NBITS-1:0] resData,
    input wire logic resReady,
    // Device pins
    output logic convertStrobe,
    output logic selectModeInput,
    output logic shiftClock,
    input wire logic serialResultOut
);
    localparam int NSH = NBITS + 1;
    sac_state_t state_r, state_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [5:0] bitCnt_r, bitCnt_nxt;
    logic [NSH-1:0] shReg_r, shReg_nxt;
    logic [1:0] mode_r, mode_nxt;
    sac_pins_t pins_r, pins_nxt;
    logic [1:0] sdoSync_r;
    logic inValid, inReady;
    logic [NBITS-1:0] inData;
    logic busyMode, fourWire;
    logic [5:0] needFalls;

    assign busyMode = mode_r[0];
    assign fourWire = mode_r[1];
    // Busy bit consumes one extra fall
    assign needFalls = busyMode ? 6'(NBITS + 1) : 6'(NBITS); // [RULE5]

    // Two flops before any logic looks at the data pin
    always_ff @(posedge clock) begin
        if (!nrst) sdoSync_r <= 2'h0;
        else sdoSync_r <= {sdoSync_r[0], serialResultOut};
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        bitCnt_nxt = bitCnt_r;
        shReg_nxt = shReg_r;
        mode_nxt = mode_r;
        pins_nxt = pins_r;
        inValid = 1'b0;
        inData = shReg_r[NBITS-1:0];
        case (state_r)
            SAC_IDLE: begin
                pins_nxt = '{convertStrobe: 1'b0, selectModeInput: 1'b1,
                             shiftClock: 1'b0};
                if (startReq && inReady) begin
                    mode_nxt = modeSel;
                    cnt_nxt = 16'h0000;
                    state_nxt = SAC_SETUP;
                end
            end
            SAC_SETUP: begin
                // Select already high one cycle before strobe rises
                pins_nxt.convertStrobe = 1'b1; // [RULE1] [RULE3]
                cnt_nxt = 16'h0000;
                state_nxt = SAC_CONV;
            end
            SAC_CONV: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r == 16'(SEL_SET_CYC)) begin
                    if (busyMode && !fourWire)
                        pins_nxt.convertStrobe = 1'b0; // [RULE12]
                    else if (busyMode)
                        pins_nxt.selectModeInput = 1'b0; // [RULE18] [RULE22]
                end
                // Wait past maximum time; device is free running
                if (cnt_r == 16'(CONV_CYC)) begin // [RULE4] [RULE6]
                    cnt_nxt = 16'h0000;
                    bitCnt_nxt = 6'h00;
                    shReg_nxt = '0;
                    state_nxt = busyMode ? SAC_SHIFT : SAC_SELECT;
                end
            end
            SAC_SELECT: begin
                // Strobe held high in 4-wire so both are never low
                if (fourWire)
                    pins_nxt.selectModeInput = 1'b0; // [RULE16] [RULE21]
                else
                    pins_nxt.convertStrobe = 1'b0; // [RULE7] [RULE8]
                cnt_nxt = 16'h0000;
                state_nxt = SAC_SHIFT;
            end
            SAC_SHIFT: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r == 16'(SCLK_HALF_CYC - 1)) begin
                    cnt_nxt = 16'h0000;
                    if (!pins_r.shiftClock) begin
                        // Sample on rise, mid-bit of the bit now shown
                        pins_nxt.shiftClock = 1'b1;
                        shReg_nxt = {shReg_r[NSH-2:0], sdoSync_r[1]};
                    end else begin
                        pins_nxt.shiftClock = 1'b0; // [RULE9] [RULE13]
                        bitCnt_nxt = bitCnt_r + 6'h01;
                        if (bitCnt_r + 6'h01 == needFalls) // [RULE11] [RULE14]
                            state_nxt = SAC_END;
                    end
                end
            end
            SAC_END: begin
                inValid = 1'b1;
                // Output floated at the last shift fall; strobe back low, select high
                pins_nxt = '{convertStrobe: 1'b0, selectModeInput: 1'b1,
                             shiftClock: 1'b0}; // [RULE10] [RULE17] [RULE19]
                cnt_nxt = 16'h0000;
                state_nxt = SAC_IDLE; // [RULE20] [RULE15]
            end
            default: state_nxt = SAC_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_r <= SAC_IDLE;
            cnt_r <= 16'h0000;
            bitCnt_r <= 6'h00;
            shReg_r <= '0;
            mode_r <= 2'h0;
            pins_r <= '{convertStrobe: 1'b0, selectModeInput: 1'b1,
                        shiftClock: 1'b0}; // [RULE2]
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bitCnt_r <= bitCnt_nxt;
            shReg_r <= shReg_nxt;
            mode_r <= mode_nxt;
            pins_r <= pins_nxt;
        end
    end

    // Output stage plus one queued word; starts wait while a word is queued
    // Reset does not stop a running device conversion; the user must wait
    logic [NBITS-1:0] buf_r [2];
    logic [1:0] cnt2_r, cnt2_nxt;
    logic wp_r, wp_nxt, rp_r, rp_nxt;
    logic outValid_r, outValid_nxt;
    logic [NBITS-1:0] outData_r, outData_nxt;
    logic pop;
    assign inReady = (cnt2_r == 2'h0);
    assign pop = resReady && outValid_r;

    always_comb begin
        cnt2_nxt = cnt2_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        outValid_nxt = outValid_r;
        outData_nxt = outData_r;
        if (inValid) begin
            wp_nxt = ~wp_r;
        end
        if (!outValid_r || pop) begin
            outValid_nxt = (cnt2_r != 2'h0);
            outData_nxt = buf_r[rp_r];
            if (cnt2_r != 2'h0) rp_nxt = ~rp_r;
        end
        cnt2_nxt = cnt2_r + (inValid ? 2'h1 : 2'h0)
            - (((!outValid_r || pop) && cnt2_r != 2'h0) ? 2'h1 : 2'h0);
    end

    always_ff @(posedge clock) begin
        if (inValid) buf_r[wp_r] <= inData;
        if (!nrst) begin
            cnt2_r <= 2'h0;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            outValid_r <= 1'b0;
            outData_r <= '0;
            startReady <= 1'b0;
        end else begin
            cnt2_r <= cnt2_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            outValid_r <= outValid_nxt;
            outData_r <= outData_nxt;
            startReady <= (state_nxt == SAC_IDLE) && (cnt2_nxt == 2'h0);
        end
    end

    assign resValid = outValid_r;
    assign resData = outData_r;
    assign convertStrobe = pins_r.convertStrobe;
    assign selectModeInput = pins_r.selectModeInput;
    assign shiftClock = pins_r.shiftClock;

    chk_fourwire_never_both: assert property (@(posedge clock) disable iff
        (!nrst) mode_r[1] |-> (convertStrobe || selectModeInput))
        else $error("strobe and select low together"); // [RULE21]
    chk_select_before_rise: assert property (@(posedge clock) disable iff
        (!nrst) $rose(convertStrobe) |-> selectModeInput)
        else $error("select low at strobe rise"); // [RULE1]
    chk_threewire_sel_high: assert property (@(posedge clock) disable iff
        (!nrst) !mode_r[1] |-> selectModeInput)
        else $error("select not high in 3-wire"); // [RULE7]
    chk_sclk_idle_conv: assert property (@(posedge clock) disable iff
        (!nrst) (state_r == SAC_CONV) |-> !shiftClock)
        else $error("shift clock toggles during conversion"); // [RULE4]
    chk_busy_strobe_low: assert property (@(posedge clock) disable iff
        (!nrst) (state_r == SAC_CONV && cnt_r == 16'(CONV_CYC) &&
        mode_r == MODE_3W_B) |-> !convertStrobe)
        else $error("strobe high at end in busy mode"); // [RULE12]
    chk_nobusy_strobe_high: assert property (@(posedge clock) disable iff
        (!nrst) (state_r == SAC_CONV && mode_r[0] == 1'b0) |-> convertStrobe)
        else $error("strobe low in no-busy conversion"); // [RULE8]
    chk_fourwire_busy_sel: assert property (@(posedge clock) disable iff
        (!nrst) (state_r == SAC_CONV && cnt_r == 16'(CONV_CYC) &&
        mode_r == MODE_4W_B) |-> !selectModeInput)
        else $error("select high at end in busy mode"); // [RULE18]
    chk_fall_count: assert property (@(posedge clock) disable iff
        (!nrst) (state_r == SAC_END) |-> (bitCnt_r == needFalls))
        else $error("wrong shift clock fall count"); // [RULE11] [RULE14]
    cov_3w_nb: cover property (@(posedge clock) state_r == SAC_END &&
        mode_r == MODE_3W_NB);
    cov_3w_b: cover property (@(posedge clock) state_r == SAC_END &&
        mode_r == MODE_3W_B);
    cov_4w_b: cover property (@(posedge clock) state_r == SAC_END &&
        mode_r == MODE_4W_B);
    cov_stall: cover property (@(posedge clock) resValid && !resReady);
endmodule
`default_nettype wire

// [sac_pkg.sv]
// Shared constants and types for the converter readout host
`default_nettype none
package sac_pkg;
    localparam int RESULT_BITS = 16;
    // Conversion time windows in ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_MIN_NS = 1400;
    localparam int CONV_MAX_NS = 1600;
    localparam int CONV_MIN_CYC = CONV_MIN_NS / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC = (CONV_MAX_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Early point to set select level, well before minimum time
    localparam int SEL_SET_CYC = CONV_MIN_CYC / 2;
    localparam int SCLK_HALF_CYC = 4;
    localparam int GAP_CYC = 4;
    localparam logic [1:0] MODE_3W_NB = 2'h0;
    localparam logic [1:0] MODE_3W_B = 2'h1;
    localparam logic [1:0] MODE_4W_NB = 2'h2;
    localparam logic [1:0] MODE_4W_B = 2'h3;
    typedef enum logic [2:0] {
        SAC_IDLE, SAC_SETUP, SAC_CONV, SAC_SELECT, SAC_SHIFT, SAC_END
    } sac_state_t;
    typedef struct packed {
        logic convertStrobe;
        logic selectModeInput;
        logic shiftClock;
    } sac_pins_t;
endpackage
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the converter readout host
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sac_pkg::*;
    logic clock, nrst, startReq, resReady, startReady, resValid;
    logic convertStrobe, selectModeInput, shiftClock, serialResultOut;
    logic chainSeen, busySent;
    logic [1:0] modeSel;
    logic [15:0] resData, sampleWord;
    int n_mismatch = 0;
    int checked = 0;
    sac_host dut (.clock(clock), .nrst(nrst), .startReq(startReq),
        .modeSel(modeSel), .startReady(startReady), .resValid(resValid),
        .resData(resData), .resReady(resReady),
        .convertStrobe(convertStrobe), .selectModeInput(selectModeInput),
        .shiftClock(shiftClock), .serialResultOut(serialResultOut));
    sac_adc_model #(.CONV_CYC(150)) adc (.clock(clock),
        .convertStrobe(convertStrobe), .selectModeInput(selectModeInput),
        .shiftClock(shiftClock), .serialResultOut(serialResultOut),
        .sampleWord(sampleWord), .chainSeen(chainSeen),
        .busySent(busySent));
    task automatic cmp(input string what, input logic [15:0] exp, got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic start_conv(input logic [1:0] mode, input logic [15:0] w);
        modeSel = mode;
        sampleWord = w;
        for (int i = 0; i < 50 && startReady !== 1'h1; i++) @(negedge clock);
        cmp("startReady", 16'h1, {15'h0, startReady});
        startReq = 1'h1;
        @(negedge clock);
        startReq = 1'h0;
    endtask
    task automatic take_result(input logic [15:0] w, input logic busy);
        for (int i = 0; i < 600 && resValid !== 1'h1; i++) @(negedge clock);
        cmp("resValid", 16'h1, {15'h0, resValid});
        cmp("resData", w, resData);
        cmp("busy bit", {15'h0, busy}, {15'h0, busySent});
        cmp("chain mode", 16'h0, {15'h0, chainSeen});
        resReady = 1'h1;
        @(negedge clock);
        resReady = 1'h0;
    endtask
    // Every mode, words with both end bits set and clear
    task automatic test_modes();
        logic [15:0] w [4] = '{16'hA5C3, 16'h8001, 16'h7FFE, 16'h0F0F};
        for (int m = 0; m < 4; m++) begin
            start_conv(m[1:0], w[m]);
            take_result(w[m], m[0]);
        end
    endtask
    // Consumer stalls; one more word may queue, then starts are refused
    task automatic test_stall();
        start_conv(MODE_4W_B, 16'hC0DE);
        for (int i = 0; i < 600 && resValid !== 1'h1; i++) @(negedge clock);
        sampleWord = 16'hBEEF;
        startReq = 1'h1;
        repeat (400) @(negedge clock);
        cmp("held valid", 16'h1, {15'h0, resValid});
        cmp("held data", 16'hC0DE, resData);
        cmp("full ready", 16'h0, {15'h0, startReady});
        cmp("refused start", 16'h0, {15'h0, convertStrobe});
        startReq = 1'h0;
        take_result(16'hC0DE, 1'h1);
        take_result(16'hBEEF, 1'h1);
    endtask
    // Reset in mid-conversion, then a clean busy and a clean no-busy conversion
    task automatic test_reset_mid();
        start_conv(MODE_3W_NB, 16'h1234);
        repeat (40) @(negedge clock);
        nrst = 1'h0;
        repeat (2) @(negedge clock);
        cmp("reset pins", 16'h2,
            {13'h0, convertStrobe, selectModeInput, shiftClock});
        nrst = 1'h1;
        @(negedge clock);
        cmp("ready after reset", 16'h1, {15'h0, startReady});
        // Cut conversion still runs in the device; let it finish
        repeat (200) @(negedge clock);
        start_conv(MODE_3W_B, 16'hFFFF);
        take_result(16'hFFFF, 1'h1);
        start_conv(MODE_3W_NB, 16'h0001);
        take_result(16'h0001, 1'h0);
    endtask
    always @(negedge clock) begin
        if (nrst === 1'h1 && modeSel[1] === 1'h1) begin
            cmp("strobe or select", 16'h1,
                {15'h0, convertStrobe | selectModeInput});
        end
        if (nrst === 1'h1 && modeSel[1] === 1'h0) begin
            cmp("select held", 16'h1, {15'h0, selectModeInput});
        end
    end
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    initial begin
        nrst = 1'h0;
        startReq = 1'h0;
        resReady = 1'h0;
        modeSel = MODE_3W_NB;
        sampleWord = 16'h0;
        repeat (5) @(negedge clock);
        nrst = 1'h1;
        test_modes();
        test_stall();
        test_reset_mid();
        tally_and_finish();
    end
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
